// [src/sdcr_pkg.sv]
// Purpose: Shared constants for the stepper driver control register bank
// Assumes: 100 MHz system clock, 16-bit serial frames
// Notes:   Times are kept in ns and converted to cycles by functions
package sdcr_pkg;

	// ----------------------------------------
	// Clock and serial frame
	// ----------------------------------------
	localparam int         CLK_MHZ     = 100;
	localparam int         FRAME_BITS  = 16;
	localparam logic [4:0] FRAME_CNT   = 5'h10;
	localparam logic [4:0] ADDR_CNT    = 5'h07;

	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [4:0] ADDR_BRIDGE = 5'h04;
	localparam logic [4:0] ADDR_STEP   = 5'h05;
	localparam logic [4:0] ADDR_PROT   = 5'h06;
	localparam logic [4:0] ADDR_BLANK  = 5'h07;
	localparam logic [7:0] RST_BRIDGE  = 8'h0f;
	localparam logic [7:0] RST_STEP    = 8'h06;
	localparam logic [7:0] RST_PROT    = 8'h38;
	localparam logic [7:0] RST_BLANK   = 8'h49;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int B_EN_OUT    = 7;
	localparam int B_SLEW      = 6;
	localparam int B_INDEXER_POSITION_RESET   = 5;
	localparam int B_OFF_TIME_SELECT      = 3;
	localparam int B_DECAY     = 0;
	localparam int B_DIR       = 7;
	localparam int B_STEP      = 6;
	localparam int B_DIR_SRC   = 5;
	localparam int B_STEP_SRC  = 4;
	localparam int B_RES       = 0;
	localparam int B_CLR       = 7;
	localparam int B_LOCK      = 4;
	localparam int B_OVERCURRENT_DEGLITCH_SELECT      = 3;
	localparam int B_OVERCURRENT_RECOVERY_SELECT  = 2;
	localparam int B_THERMAL_RECOVERY_SELECT = 1;
	localparam int B_TW_REP    = 0;
	localparam int B_BLANK     = 6;
	localparam int B_LEARN     = 5;
	localparam int B_STL_EN    = 4;
	localparam int B_STALL_REPORT_ENABLE   = 3;
	localparam int B_FLT_BYP   = 2;
	localparam int B_FLT_TOL   = 0;

	localparam logic [2:0] LOCK_CODE   = 3'h6;
	localparam logic [2:0] UNLOCK_CODE = 3'h3;

	// ----------------------------------------
	// Timing, ns as printed
	// ----------------------------------------
	localparam int OCP_SHORT_NS = 1200;
	localparam int OCP_LONG_NS  = 2200;
	localparam int TOFF0_NS     = 9500;
	localparam int TOFF1_NS     = 19000;
	localparam int TOFF2_NS     = 27000;
	localparam int TOFF3_NS     = 35000;
	localparam int BLANK0_NS    = 1000;
	localparam int BLANK1_NS    = 1500;
	localparam int BLANK2_NS    = 2000;
	localparam int BLANK3_NS    = 2500;

	// Least times round up to whole cycles
	function automatic logic [15:0] ns_cyc(input int ns);
		ns_cyc = 16'((ns * CLK_MHZ + 999) / 1000);
	endfunction : ns_cyc

	localparam logic [15:0] OCP_SHORT_CYC = ns_cyc(OCP_SHORT_NS);
	localparam logic [15:0] OCP_LONG_CYC  = ns_cyc(OCP_LONG_NS);

	// ----------------------------------------
	// Indexer: 1024 units per electrical cycle
	// ----------------------------------------
	localparam int         IDX_W    = 10;
	localparam logic [9:0] IDX_HOME = 10'h080;
	localparam logic [3:0] RES_MAX  = 4'ha;

endpackage : sdcr_pkg

// [src/sdcr_regs.sv]
// Purpose: Control registers of a serial-configured stepper driver
// Assumes: SPI mode 1, 16-bit frames, pins slower than the system clock
// Notes:   Self-clearing command bits other than learn act on the write and are never stored
// Contract
// - Bridge outputs driven only while output enable is 1
// - Slew bit picks 140 ns (0) or 70 ns (1) edges
// - Indexer reset returns position to 45 degrees, registers untouched
// - Off-time code selects 9.5, 19, 27 or 35 us
// - Decay code selects slow, mixed 30/60, dynamic or ripple scheme
// - Register direction: 1 forward, 0 reverse
// - Register step bit advances indexer exactly once, then clears
// - Direction source: 0 pin, 1 register bit
// - Step source: 0 pin, 1 register step bit
// - Resolution code selects full step through 1/256 step
// - Fault clear wipes latched faults and clears itself
// - Writing 110 locks; locked device ignores all but lock and clear
// - Only 011 unlocks; other values keep the device locked
// - Overcurrent deglitch: 1 gives 2.2 us, 0 gives 1.2 us
// - Overcurrent latches when recovery bit 0, auto-retries when 1
// - Overtemperature latches when recovery bit 0, auto-retries when 1
// - Temperature warning reported on fault pin only when bit is 1
// - Stall learn runs after writing 1, bit clears when finished
// - Blanking code selects 1, 1.5, 2 or 2.5 us
`timescale 1ns/1ps
module sdcr_regs
#(
	parameter int LEARN_CYC = 1000,
	parameter int CNT_W     = 16
) (
	input  wire logic                 I_CLK_SYS,
	input  wire logic                 I_RST_N,
	input  wire logic                 I_SPI_SCLK,
	input  wire logic                 I_SPI_SDI,
	input  wire logic                 I_SPI_CS_N,
	output logic                      O_SPI_SDO,
	output logic                      O_SPI_SDO_OE,
	input  wire logic                 I_STEP_PIN,
	input  wire logic                 I_DIR_PIN,
	input  wire logic                 I_OCP_RAW,
	input  wire logic                 I_OTS_RAW,
	input  wire logic                 I_TEMP_WARN_RAW,
	input  wire logic                 I_STALL_RAW,
	output logic                      O_BRIDGE_EN,
	output logic                      O_SLEW_FAST,
	output logic [11:0]               O_OFF_TIME_CYC,
	output logic [2:0]                O_DECAY_SEL,
	output logic [3:0]                O_RES_SEL,
	output logic                      O_STEP_PULSE,
	output logic                      O_STEP_DIR_FWD,
	output logic [sdcr_pkg::IDX_W-1:0] O_INDEX_POS,
	output logic [11:0]               O_BLANK_CYC,
	output logic                      O_STALL_DETECT_EN,
	output logic                      O_STALL_LEARN_ACTIVE,
	output logic                      O_PULSE_FILTER_BYPASS,
	output logic [1:0]                O_PULSE_FILTER_TOL,
	output logic                      O_FAULT_OUT_N
);
	import sdcr_pkg::*;
	generate
		if (CNT_W < 16 || LEARN_CYC < 1 || LEARN_CYC >= (1 << CNT_W)) begin : g_chk
			$error("sdcr_regs: LEARN_CYC must be 1 .. 2**CNT_W-1, CNT_W at least 16");
		end
	endgenerate
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [11:0] off_cyc(input logic [1:0] c);
		unique case (c)
			2'h0: off_cyc = 12'(ns_cyc(TOFF0_NS));
			2'h1: off_cyc = 12'(ns_cyc(TOFF1_NS));
			2'h2: off_cyc = 12'(ns_cyc(TOFF2_NS));
			2'h3: off_cyc = 12'(ns_cyc(TOFF3_NS));
		endcase
	endfunction : off_cyc
	function automatic logic [11:0] blank_cyc(input logic [1:0] c);
		unique case (c)
			2'h0: blank_cyc = 12'(ns_cyc(BLANK0_NS));
			2'h1: blank_cyc = 12'(ns_cyc(BLANK1_NS));
			2'h2: blank_cyc = 12'(ns_cyc(BLANK2_NS));
			2'h3: blank_cyc = 12'(ns_cyc(BLANK3_NS));
		endcase
	endfunction : blank_cyc
	// Indexer units per step; reserved codes do not move the indexer
	function automatic logic [IDX_W-1:0] step_size(input logic [3:0] c);
		if (c > RES_MAX)
			step_size = '0;
		else if (c <= 4'h1)
			step_size = 10'h100;
		else if (c == 4'h2)
			step_size = 10'h080;
		else
			step_size = 10'(11'h400 >> c);
	endfunction : step_size
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int         NSYNC    = 9;
	localparam logic [8:0] SYNC_RST = 9'h004;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
	logic             sclk_f, sdi_f, csn_f, step_f, dir_f, ocp_f, ots_f, otw_f, stall_f;

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			s1_q   <= SYNC_RST;
			s2_q   <= SYNC_RST;
			s3_q   <= SYNC_RST;
			filt_q <= SYNC_RST;
			prev_q <= SYNC_RST;
		end else begin
			s1_q   <= {I_STALL_RAW, I_TEMP_WARN_RAW, I_OTS_RAW, I_OCP_RAW, I_DIR_PIN,
			           I_STEP_PIN, I_SPI_CS_N, I_SPI_SDI, I_SPI_SCLK};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			// A change counts only once two stages agree
			filt_q <= (filt_q & (s2_q ^ s3_q)) |
			          (s3_q & ~(s2_q ^ s3_q));
			prev_q <= filt_q;
		end
	end

	assign {stall_f, otw_f, ots_f, ocp_f, dir_f, step_f, csn_f, sdi_f, sclk_f} = filt_q;

	wire sclk_rise = sclk_f & ~prev_q[0];
	wire sclk_fall = ~sclk_f & prev_q[0];
	wire cs_fall   = ~csn_f & prev_q[2];
	wire cs_rise   = csn_f & ~prev_q[2];
	wire step_rise = step_f & ~prev_q[3];

	// ----------------------------------------
	// Serial frame engine
	// ----------------------------------------
	logic [15:0] rx_q, tx_q;
	logic [4:0]  bit_cnt_q;
	logic [7:0]  bridge_output_config_q, step_source_and_resolution_q, protection_and_lock_config_q, blanking_and_stall_config_q;
	logic        locked_q;

	function automatic logic [7:0] reg_read(input logic [4:0] a);
		unique case (a)
			ADDR_BRIDGE: reg_read = bridge_output_config_q;
			ADDR_STEP:   reg_read = step_source_and_resolution_q;
			ADDR_PROT:   reg_read = {1'b0, locked_q ? LOCK_CODE : UNLOCK_CODE, protection_and_lock_config_q[3:0]};
			ADDR_BLANK:  reg_read = blanking_and_stall_config_q;
			default:     reg_read = 8'h00;
		endcase
	endfunction : reg_read
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N || cs_fall) begin
			rx_q      <= 16'h0000;
			tx_q      <= 16'h0000;
			bit_cnt_q <= 5'h00;
			O_SPI_SDO <= 1'b0;
		end else if (!csn_f) begin
			if (sclk_rise) begin
				O_SPI_SDO <= tx_q[15];
				tx_q      <= {tx_q[14:0], 1'b0};
			end else if (sclk_fall) begin
				rx_q <= {rx_q[14:0], sdi_f};
				if (bit_cnt_q != 5'h1f)
					bit_cnt_q <= bit_cnt_q + 5'h01;
				// Address is complete here; answer goes out in the low byte
				if (bit_cnt_q == ADDR_CNT)
					tx_q[15:8] <= reg_read(rx_q[4:0]);
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			O_SPI_SDO_OE <= 1'b0;
		else
			O_SPI_SDO_OE <= ~csn_f;
	end

	// Write commits when chip select rises after exactly one frame
	wire       wr_stb  = cs_rise && (bit_cnt_q == FRAME_CNT) && !rx_q[14];
	wire [4:0] wr_addr = rx_q[13:9];
	wire [7:0] wr_data = rx_q[7:0];
	wire       wr_any  = wr_stb && !locked_q;

	// ----------------------------------------
	// Register storage and command pulses
	// ----------------------------------------
	logic idx_cmd_q, step_cmd_q, clr_cmd_q, learn_done;

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			bridge_output_config_q  <= RST_BRIDGE;
			step_source_and_resolution_q  <= RST_STEP;
			protection_and_lock_config_q  <= RST_PROT;
			blanking_and_stall_config_q  <= RST_BLANK;
			locked_q <= 1'b0;
		end else begin
			// Self-clearing bits other than learn are never stored, so they read back as zero
			if (wr_any && wr_addr == ADDR_BRIDGE)
				bridge_output_config_q <= wr_data & ~(8'h01 << B_INDEXER_POSITION_RESET);
			if (wr_any && wr_addr == ADDR_STEP)
				step_source_and_resolution_q <= wr_data & ~(8'h01 << B_STEP);
			if (wr_any && wr_addr == ADDR_PROT)
				protection_and_lock_config_q <= {4'h0, wr_data[3:0]};
			if (wr_any && wr_addr == ADDR_BLANK)
				blanking_and_stall_config_q <= wr_data;
			else if (learn_done)
				blanking_and_stall_config_q[B_LEARN] <= 1'b0;
			if (wr_stb && wr_addr == ADDR_PROT) begin
				if (!locked_q && wr_data[B_LOCK+:3] == LOCK_CODE)
					locked_q <= 1'b1;
				else if (locked_q && wr_data[B_LOCK+:3] == UNLOCK_CODE)
					locked_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			idx_cmd_q  <= 1'b0;
			step_cmd_q <= 1'b0;
			clr_cmd_q  <= 1'b0;
		end else begin
			idx_cmd_q  <= wr_any && wr_addr == ADDR_BRIDGE && wr_data[B_INDEXER_POSITION_RESET];
			step_cmd_q <= wr_any && wr_addr == ADDR_STEP && wr_data[B_STEP] &&
			              wr_data[B_STEP_SRC];
			// Fault clear is honoured even while locked
			clr_cmd_q  <= wr_stb && wr_addr == ADDR_PROT && wr_data[B_CLR];
		end
	end

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_SLEW_FAST           <= 1'b0;
			O_OFF_TIME_CYC        <= 12'h000;
			O_DECAY_SEL           <= 3'h0;
			O_RES_SEL             <= 4'h0;
			O_BLANK_CYC           <= 12'h000;
			O_STALL_DETECT_EN     <= 1'b0;
			O_STALL_LEARN_ACTIVE  <= 1'b0;
			O_PULSE_FILTER_BYPASS <= 1'b0;
			O_PULSE_FILTER_TOL    <= 2'h0;
		end else begin
			O_SLEW_FAST           <= bridge_output_config_q[B_SLEW];
			O_OFF_TIME_CYC        <= off_cyc(bridge_output_config_q[B_OFF_TIME_SELECT+:2]);
			// Reserved decay and resolution codes pass through untouched
			O_DECAY_SEL           <= bridge_output_config_q[B_DECAY+:3];
			O_RES_SEL             <= step_source_and_resolution_q[B_RES+:4];
			O_BLANK_CYC           <= blank_cyc(blanking_and_stall_config_q[B_BLANK+:2]);
			O_STALL_DETECT_EN     <= blanking_and_stall_config_q[B_STL_EN];
			O_STALL_LEARN_ACTIVE  <= blanking_and_stall_config_q[B_LEARN];
			O_PULSE_FILTER_BYPASS <= blanking_and_stall_config_q[B_FLT_BYP];
			O_PULSE_FILTER_TOL    <= blanking_and_stall_config_q[B_FLT_TOL+:2];
		end
	end

	// ----------------------------------------
	// Stepping and indexer
	// ----------------------------------------
	wire dir_fwd  = step_source_and_resolution_q[B_DIR_SRC] ? step_source_and_resolution_q[B_DIR] : dir_f;
	wire step_evt = step_source_and_resolution_q[B_STEP_SRC] ? step_cmd_q : step_rise;

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_STEP_PULSE   <= 1'b0;
			O_STEP_DIR_FWD <= 1'b0;
			O_INDEX_POS    <= IDX_HOME;
		end else begin
			O_STEP_PULSE   <= step_evt;
			O_STEP_DIR_FWD <= dir_fwd;
			if (idx_cmd_q)
				O_INDEX_POS <= IDX_HOME;
			else if (step_evt && dir_fwd)
				O_INDEX_POS <= O_INDEX_POS + step_size(step_source_and_resolution_q[B_RES+:4]);
			else if (step_evt)
				O_INDEX_POS <= O_INDEX_POS - step_size(step_source_and_resolution_q[B_RES+:4]);
		end
	end

	// ----------------------------------------
	// Protection and fault pin
	// ----------------------------------------
	logic ocp_hit, ocp_flt_q, ots_flt_q, stall_flt_q;

	sdcr_timer #(.CNT_W(CNT_W)) u_ocp_deglitch (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_run   (ocp_f),
		.i_limit (CNT_W'(protection_and_lock_config_q[B_OVERCURRENT_DEGLITCH_SELECT] ? OCP_LONG_CYC : OCP_SHORT_CYC)),
		.o_done  (ocp_hit)
	);

	sdcr_timer #(.CNT_W(CNT_W)) u_learn (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_run   (blanking_and_stall_config_q[B_LEARN]),
		.i_limit (CNT_W'(LEARN_CYC)),
		.o_done  (learn_done)
	);

	// A new fault in the cycle of a clear wins over the clear
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ocp_flt_q   <= 1'b0;
			ots_flt_q   <= 1'b0;
			stall_flt_q <= 1'b0;
		end else begin
			if (ocp_hit)
				ocp_flt_q <= 1'b1;
			else if (clr_cmd_q || (protection_and_lock_config_q[B_OVERCURRENT_RECOVERY_SELECT] && !ocp_f))
				ocp_flt_q <= 1'b0;
			if (ots_f)
				ots_flt_q <= 1'b1;
			else if (clr_cmd_q || protection_and_lock_config_q[B_THERMAL_RECOVERY_SELECT])
				ots_flt_q <= 1'b0;
			if (stall_f && blanking_and_stall_config_q[B_STL_EN])
				stall_flt_q <= 1'b1;
			else if (clr_cmd_q)
				stall_flt_q <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_BRIDGE_EN   <= 1'b0;
			O_FAULT_OUT_N <= 1'b1;
		end else begin
			O_BRIDGE_EN   <= bridge_output_config_q[B_EN_OUT] && !ocp_flt_q && !ots_flt_q;
			O_FAULT_OUT_N <= !(ocp_flt_q || ots_flt_q ||
			                   (otw_f && protection_and_lock_config_q[B_TW_REP]) ||
			                   (stall_flt_q && blanking_and_stall_config_q[B_STALL_REPORT_ENABLE]));
		end
	end

endmodule : sdcr_regs

// [src/sdcr_timer.sv]
// Purpose: Persistence timer, done once run has held for limit cycles
// Assumes: i_run is a synchronous level
// Notes:   Dropping i_run restarts the count
`timescale 1ns/1ps
module sdcr_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_run,
	input  wire logic [CNT_W-1:0] i_limit,
	output logic                  o_done
);
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_run) begin
			cnt_q  <= '0;
			o_done <= 1'b0;
		end else if (cnt_q >= i_limit) begin
			o_done <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule : sdcr_timer

// [tb/sdcr_regs_assertions.sv]
// Purpose: Port-level checks for the control register bank
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Pin and serial paths add a few cycles of latency
`timescale 1ns/1ps
module sdcr_regs_assertions
	import sdcr_pkg::*;
(
	input wire logic                          I_CLK_SYS,
	input wire logic                          I_RST_N,
	input wire logic                          I_SPI_CS_N,
	input wire logic                          O_SPI_SDO_OE,
	input wire logic                          I_STEP_PIN,
	input wire logic                          I_OCP_RAW,
	input wire logic                          I_OTS_RAW,
	input wire logic                          I_TEMP_WARN_RAW,
	input wire logic                          I_STALL_RAW,
	input wire logic                          O_BRIDGE_EN,
	input wire logic [11:0]                   O_OFF_TIME_CYC,
	input wire logic [3:0]                    O_RES_SEL,
	input wire logic                          O_STEP_PULSE,
	input wire logic [sdcr_pkg::IDX_W-1:0]    O_INDEX_POS,
	input wire logic [11:0]                   O_BLANK_CYC,
	input wire logic                          O_FAULT_OUT_N
);
	logic [7:0] ocp_run_q;
	logic [3:0] since_q;

	function automatic logic [9:0] sz(input logic [3:0] c);
		return c < 4'h2 ? 10'h100 : c < 4'h4 ? 10'h080 : 10'h100 >> (c - 4'h2);
	endfunction : sz

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N || !I_OCP_RAW)
			ocp_run_q <= 8'h00;
		else
			ocp_run_q <= ocp_run_q + {7'h00, ocp_run_q != 8'hff};
	end

	// A step needs a recent pin edge or end of frame
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			since_q <= 4'hf;
		else if ($rose(I_STEP_PIN) || $rose(I_SPI_CS_N))
			since_q <= 4'h0;
		else
			since_q <= since_q + {3'h0, since_q != 4'hf};
	end

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);

	bridge_reset_off_a: assert property ($rose(I_RST_N) |-> !O_BRIDGE_EN)
		else $error("bridge enabled at reset release");
	off_time_code_a: assert property ($past(I_RST_N, 2) |-> O_OFF_TIME_CYC inside
		{12'h3b6, 12'h76c, 12'ha8c, 12'hdac}) else $error("off time out of table");
	blank_code_a: assert property ($past(I_RST_N, 2) |-> O_BLANK_CYC inside
		{12'h064, 12'h096, 12'h0c8, 12'h0fa}) else $error("blanking out of table");
	step_one_cycle_a: assert property (O_STEP_PULSE |=> !O_STEP_PULSE)
		else $error("step pulse longer than one cycle");
	step_has_cause_a: assert property ($rose(O_STEP_PULSE) |-> since_q <= 4'hc)
		else $error("step without pin edge or frame");
	index_moves_step_a: assert property ($changed(O_INDEX_POS) |-> O_INDEX_POS == IDX_HOME
		|| O_STEP_PULSE || $past(O_STEP_PULSE) || $past(O_STEP_PULSE, 2))
		else $error("indexer moved without step");
	index_step_size_a: assert property ($changed(O_INDEX_POS) && O_INDEX_POS != IDX_HOME
		|-> (O_INDEX_POS - $past(O_INDEX_POS)) == sz(O_RES_SEL)
		|| ($past(O_INDEX_POS) - O_INDEX_POS) == sz(O_RES_SEL)) else $error("wrong step size");
	ocp_deglitch_a: assert property ($fell(O_FAULT_OUT_N) && I_OCP_RAW && !I_OTS_RAW
		&& !I_TEMP_WARN_RAW && !I_STALL_RAW |-> ocp_run_q >= 8'h78)
		else $error("overcurrent fault before deglitch time");
	sdo_oe_frame_a: assert property ($fell(I_SPI_CS_N) |-> ##6 O_SPI_SDO_OE)
		else $error("data out not enabled during frame");
	sdo_oe_idle_a: assert property ($rose(I_SPI_CS_N) |-> ##6 !O_SPI_SDO_OE)
		else $error("data out still enabled after frame");
endmodule : sdcr_regs_assertions

bind sdcr_regs sdcr_regs_assertions u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
	.I_SPI_CS_N(I_SPI_CS_N), .O_SPI_SDO_OE(O_SPI_SDO_OE), .I_STEP_PIN(I_STEP_PIN),
	.I_OCP_RAW(I_OCP_RAW), .I_OTS_RAW(I_OTS_RAW), .I_TEMP_WARN_RAW(I_TEMP_WARN_RAW),
	.I_STALL_RAW(I_STALL_RAW), .O_BRIDGE_EN(O_BRIDGE_EN), .O_OFF_TIME_CYC(O_OFF_TIME_CYC),
	.O_RES_SEL(O_RES_SEL), .O_STEP_PULSE(O_STEP_PULSE), .O_INDEX_POS(O_INDEX_POS),
	.O_BLANK_CYC(O_BLANK_CYC), .O_FAULT_OUT_N(O_FAULT_OUT_N));

// [tb/sdcr_regs_bench.sv]
// Purpose: Self-checking bench for the control register bank
// Assumes: Host model reaches registers over SPI
// Notes:   Stall learn shortened to 10 cycles
`timescale 1ns/1ps
module sdcr_regs_bench;
	import sdcr_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, sclk, sdi, cs_n, sdo, sdo_oe;
	logic        pin_s = 1'b0, pin_d = 1'b0, ocp = 1'b0, ots = 1'b0, warn = 1'b0, stall = 1'b0;
	logic        bridge, slew, pulse, fwd, learn, det, byp, fault_n;
	logic [11:0] off_time_select_c, blank_c;
	logic [2:0]  decay;
	logic [3:0]  res;
	logic [9:0]  pos;
	logic [1:0]  tol;
	logic [7:0]  d1, d2, d3, d4;
	logic [31:0] seed = 32'hb24f, r;
	int          miscompares = 0, total_checks = 0, cyc = 0;
	logic [2:0]  dec[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};

	sdcr_spi_host host (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_sdi(sdi), .o_cs_n(cs_n));
	sdcr_regs #(.LEARN_CYC(10)) u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SPI_SCLK(sclk),
		.I_SPI_SDI(sdi), .I_SPI_CS_N(cs_n), .O_SPI_SDO(sdo), .O_SPI_SDO_OE(sdo_oe),
		.I_STEP_PIN(pin_s), .I_DIR_PIN(pin_d), .I_OCP_RAW(ocp), .I_OTS_RAW(ots),
		.I_TEMP_WARN_RAW(warn), .I_STALL_RAW(stall), .O_BRIDGE_EN(bridge),
		.O_SLEW_FAST(slew), .O_OFF_TIME_CYC(off_time_select_c), .O_DECAY_SEL(decay), .O_RES_SEL(res),
		.O_STEP_PULSE(pulse), .O_STEP_DIR_FWD(fwd), .O_INDEX_POS(pos), .O_BLANK_CYC(blank_c),
		.O_STALL_DETECT_EN(det), .O_STALL_LEARN_ACTIVE(learn), .O_PULSE_FILTER_BYPASS(byp),
		.O_PULSE_FILTER_TOL(tol), .O_FAULT_OUT_N(fault_n));

	always #5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [11:0] off_time_select(input logic [1:0] c);
		return c == 2'h0 ? 12'h3b6 : c == 2'h1 ? 12'h76c : c == 2'h2 ? 12'ha8c : 12'hdac;
	endfunction : off_time_select

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] rd;
		host.xfer({2'b00, a, 1'b0, d}, rd);
		tick(9);
	endtask : wr

	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] rd;
		host.xfer({2'b01, a, 9'h000}, rd);
		chk(16'(rd), 16'(e));
	endtask : rdc

	task automatic blip();
		ots = 1'b1;
		tick(10);
		ots = 1'b0;
		tick(10);
	endtask : blip

	task automatic wrap_up();
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// Cuts a hang short; the sequence needs about 32000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 70000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		tick(3);
		rst_n = 1'b1;
		tick(8);
		rdc(ADDR_BRIDGE, RST_BRIDGE);
		rdc(ADDR_STEP, RST_STEP);
		rdc(ADDR_PROT, RST_PROT);
		rdc(ADDR_BLANK, RST_BLANK);
		rdc(5'h1f, 8'h00);
		for (int i = 0; i < 11; i++) begin
			r = rnd();
			host.hp = 6 + i % 4;
			pin_d = r[6];
			d1 = {r[3], r[0], 1'b0, r[2:1], dec[i % 5]};
			d2 = {r[4], 1'b0, r[5], 1'b0, 4'(i)};
			d3 = {4'h3, r[17:14]};
			d4 = {r[8:7], 1'b0, r[13:9]};
			wr(ADDR_BRIDGE, d1);
			wr(ADDR_STEP, d2);
			wr(ADDR_PROT, d3);
			wr(ADDR_BLANK, d4);
			chk(16'({bridge, slew}), 16'(d1[7:6]));
			chk(16'(off_time_select_c), 16'(off_time_select(d1[4:3])));
			chk(16'(decay), 16'(d1[2:0]));
			chk(16'(res), 16'(d2[3:0]));
			chk(16'(fwd), 16'(d2[5] ? d2[7] : pin_d));
			chk(16'(blank_c), 16'(12'h064 + 12'h032 * d4[7:6]));
			chk(16'({det, byp, tol}), 16'({d4[4], d4[2:0]}));
			rdc(ADDR_BRIDGE, d1);
			rdc(ADDR_STEP, d2);
			rdc(ADDR_PROT, d3);
			rdc(ADDR_BLANK, d4);
		end
		wr(ADDR_STEP, 8'h35);
		wr(ADDR_STEP, 8'hf5);
		chk(16'({fwd, pos}), 16'h04a0);
		rdc(ADDR_STEP, 8'hb5);
		wr(ADDR_STEP, 8'h75);
		chk(16'({fwd, pos}), 16'h0080);
		wr(ADDR_STEP, 8'h0a);
		pin_d = 1'b1;
		pin_s = 1'b1;
		tick(10);
		pin_s = 1'b0;
		tick(10);
		chk(16'(pos), 16'h0081);
		wr(ADDR_BRIDGE, 8'hef);
		chk(16'(pos), 16'h0080);
		rdc(ADDR_BRIDGE, 8'hcf);
		wr(ADDR_PROT, 8'h00);
		rdc(ADDR_PROT, 8'h30);
		wr(ADDR_PROT, 8'h60);
		wr(ADDR_BRIDGE, 8'h00);
		rdc(ADDR_BRIDGE, 8'hcf);
		wr(ADDR_PROT, 8'h20);
		rdc(ADDR_PROT, 8'h60);
		wr(ADDR_PROT, 8'h30);
		wr(ADDR_BRIDGE, 8'h00);
		chk(16'(bridge), 16'h0000);
		wr(ADDR_BRIDGE, 8'h8f);
		ocp = 1'b1;
		tick(100);
		ocp = 1'b0;
		tick(10);
		chk(16'(bridge), 16'h0001);
		ocp = 1'b1;
		tick(140);
		ocp = 1'b0;
		tick(10);
		chk(16'({bridge, fault_n}), 16'h0000);
		wr(ADDR_PROT, 8'hb0);
		chk(16'({bridge, fault_n}), 16'h0003);
		rdc(ADDR_PROT, 8'h30);
		wr(ADDR_PROT, 8'h3c);
		ocp = 1'b1;
		tick(200);
		chk(16'(bridge), 16'h0001);
		tick(40);
		chk(16'(bridge), 16'h0000);
		ocp = 1'b0;
		tick(10);
		chk(16'(bridge), 16'h0001);
		blip();
		chk(16'(fault_n), 16'h0000);
		wr(ADDR_PROT, 8'hbc);
		chk(16'(fault_n), 16'h0001);
		wr(ADDR_PROT, 8'h3e);
		blip();
		chk(16'(fault_n), 16'h0001);
		wr(ADDR_PROT, 8'h3f);
		warn = 1'b1;
		tick(10);
		chk(16'(fault_n), 16'h0000);
		wr(ADDR_PROT, 8'h3e);
		chk(16'(fault_n), 16'h0001);
		warn = 1'b0;
		wr(ADDR_BLANK, 8'h69);
		chk(16'(learn), 16'h0001);
		rdc(ADDR_BLANK, 8'h49);
		wr(ADDR_BLANK, 8'h59);
		stall = 1'b1;
		tick(10);
		stall = 1'b0;
		tick(10);
		chk(16'(fault_n), 16'h0000);
		wr(ADDR_PROT, 8'hbe);
		chk(16'(fault_n), 16'h0001);
		wrap_up();
	end
endmodule : sdcr_regs_bench

// [tb/sdcr_spi_host.sv]
// Purpose: SPI mode 1 host model driving the register bank
// Assumes: 16-bit frames, MSB first, SCLK idles low
// Notes:   SDI shows the inverse of its last bit between frames
`timescale 1ns/1ps
module sdcr_spi_host (
	input  wire logic i_clk,
	input  wire logic i_sdo,
	output logic      o_sclk,
	output logic      o_sdi,
	output logic      o_cs_n
);
	// Half period in system cycles, six at the least
	int hp = 8;

	initial begin
		o_sclk = 1'b0;
		o_sdi  = 1'b1;
		o_cs_n = 1'b1;
	end

	task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
		repeat (hp) @(posedge i_clk);
		#1 o_cs_n = 1'b0;
		for (int b = 15; b >= 0; b--) begin
			repeat (hp) @(posedge i_clk);
			#1 o_sclk = 1'b1;
			o_sdi = f[b];
			repeat (hp) @(posedge i_clk);
			#1 o_sclk = 1'b0;
			rd = {rd[6:0], i_sdo};
		end
		repeat (hp) @(posedge i_clk);
		#1 o_cs_n = 1'b1;
		// Stale data must not look valid after the frame
		o_sdi = ~o_sdi;
	endtask : xfer
endmodule : sdcr_spi_host
